//--- verilog/rcad_consts.svh
`ifndef RCAD_CONSTS_SVH
`define RCAD_CONSTS_SVH

// ==========================================================================
// Comma patterns, first received bit (a) held in bit 0.
`define RCAD_COMMA_POS   7'h7C
`define RCAD_COMMA_NEG   7'h03

// ==========================================================================
// Sub-block codes, written with bit a (or f) as the most significant bit.
`define RCAD_K28_RDM     6'h0F
`define RCAD_K28_RDP     6'h30
`define RCAD_D7_RDM      6'h38
`define RCAD_D7_RDP      6'h07
`define RCAD_F3_RDM      4'hC
`define RCAD_F3_RDP      4'h3
`define RCAD_A7_RDM      4'h7
`define RCAD_A7_RDP      4'h8

// ==========================================================================
// Substitute byte, reference character and reset values.
`define RCAD_ERR_BYTE    8'hFF
`define RCAD_K285_SYM    10'h17C
`define RCAD_K285_BYTE   8'hBC
`define RCAD_CDET_RST    1'b1
`define RCAD_CODEC_RST   1'b0
`define RCAD_BOUND_RST   4'h0
`define RCAD_RD_RST      1'b0

`endif

//--- verilog/rcad_pkg.sv
package rcad_pkg;
  // ========================================================================
  // Shared data types.
  typedef logic [9:0] rcad_sym_t;
  typedef logic [7:0] rcad_byte_t;
  typedef logic [3:0] rcad_pos_t;
endpackage

//--- verilog/rcad_sync.sv
`timescale 1ns/10ps

// ==========================================================================
// Two flip-flop synchroniser for a level arriving on a pin.
module rcad_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- verilog/rcad_align.sv
`timescale 1ns/10ps
`include "rcad_consts.svh"

module rcad_align #(
  parameter int SYM_W  = 10,
  parameter int BYTE_W = 8
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire rcad_pkg::rcad_sym_t rx_raw_word,
  input  wire logic                codec_enable,
  input  wire logic                comma_detect_enable,
  output rcad_pkg::rcad_sym_t      rx_parallel_bus,
  output logic                     rx_k_flag,
  output logic                     rx_code_error,
  output logic                     comma_sync,
  output rcad_pkg::rcad_pos_t      boundary_pos
);

  // ========================================================================
  // Elaboration check: the datapath is built for 8b/10b only.
  if (SYM_W != 10 || BYTE_W != 8) begin : g_bad_width
    $error("rcad_align supports only 10-bit symbols and 8-bit bytes.");
  end

  // ========================================================================
  // Functions.

  // Finds the lowest bit offset holding the positive comma.
  function automatic logic [4:0] first_hit(input logic [19:0] w);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 9; i >= 0; i--) begin
      if (w[i +: 7] == `RCAD_COMMA_POS) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Counts ones in a sub-block.
  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  // Decodes abcdei into {valid, EDCBA}.
  function automatic logic [5:0] dec6(input logic [5:0] s);
    case (s)
      6'h27, 6'h18: dec6 = {1'b1, 5'h00};
      6'h1D, 6'h22: dec6 = {1'b1, 5'h01};
      6'h2D, 6'h12: dec6 = {1'b1, 5'h02};
      6'h31:        dec6 = {1'b1, 5'h03};
      6'h35, 6'h0A: dec6 = {1'b1, 5'h04};
      6'h29:        dec6 = {1'b1, 5'h05};
      6'h19:        dec6 = {1'b1, 5'h06};
      6'h38, 6'h07: dec6 = {1'b1, 5'h07};
      6'h39, 6'h06: dec6 = {1'b1, 5'h08};
      6'h25:        dec6 = {1'b1, 5'h09};
      6'h15:        dec6 = {1'b1, 5'h0A};
      6'h34:        dec6 = {1'b1, 5'h0B};
      6'h0D:        dec6 = {1'b1, 5'h0C};
      6'h2C:        dec6 = {1'b1, 5'h0D};
      6'h1C:        dec6 = {1'b1, 5'h0E};
      6'h17, 6'h28: dec6 = {1'b1, 5'h0F};
      6'h1B, 6'h24: dec6 = {1'b1, 5'h10};
      6'h23:        dec6 = {1'b1, 5'h11};
      6'h13:        dec6 = {1'b1, 5'h12};
      6'h32:        dec6 = {1'b1, 5'h13};
      6'h0B:        dec6 = {1'b1, 5'h14};
      6'h2A:        dec6 = {1'b1, 5'h15};
      6'h1A:        dec6 = {1'b1, 5'h16};
      6'h3A, 6'h05: dec6 = {1'b1, 5'h17};
      6'h33, 6'h0C: dec6 = {1'b1, 5'h18};
      6'h26:        dec6 = {1'b1, 5'h19};
      6'h16:        dec6 = {1'b1, 5'h1A};
      6'h36, 6'h09: dec6 = {1'b1, 5'h1B};
      6'h0E, 6'h0F, 6'h30: dec6 = {1'b1, 5'h1C};
      6'h2E, 6'h11: dec6 = {1'b1, 5'h1D};
      6'h1E, 6'h21: dec6 = {1'b1, 5'h1E};
      6'h2B, 6'h14: dec6 = {1'b1, 5'h1F};
      default:      dec6 = {1'b0, 5'h00};
    endcase
  endfunction

  // Decodes fghj into {valid, HGF}.
  function automatic logic [3:0] dec4(input logic [3:0] s);
    case (s)
      4'hB, 4'h4:             dec4 = {1'b1, 3'h0};
      4'h9:                   dec4 = {1'b1, 3'h1};
      4'h5:                   dec4 = {1'b1, 3'h2};
      4'hC, 4'h3:             dec4 = {1'b1, 3'h3};
      4'hD, 4'h2:             dec4 = {1'b1, 3'h4};
      4'hA:                   dec4 = {1'b1, 3'h5};
      4'h6:                   dec4 = {1'b1, 3'h6};
      4'hE, 4'h1, 4'h7, 4'h8: dec4 = {1'b1, 3'h7};
      default:                dec4 = {1'b0, 3'h0};
    endcase
  endfunction

  // ========================================================================
  // Pin synchronisers.
  logic codec_s;
  logic cdet_s;

  rcad_sync #(.RST_VAL(`RCAD_CODEC_RST)) u_sync_codec (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (codec_enable),
    .sync_out (codec_s)
  );

  rcad_sync #(.RST_VAL(`RCAD_CDET_RST)) u_sync_cdet (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (comma_detect_enable),
    .sync_out (cdet_s)
  );

  // ========================================================================
  // Alignment stage.
  rcad_pkg::rcad_sym_t raw_r;
  rcad_pkg::rcad_sym_t old_r;
  rcad_pkg::rcad_sym_t aligned_r;
  rcad_pkg::rcad_pos_t bound_r;
  logic                sync1_r;

  // Older bits sit low, so the window reads in arrival order.
  wire logic [19:0]         window    = {raw_r, old_r};
  wire logic [4:0]          hit       = first_hit(window);
  wire logic                hit_found = hit[4];
  wire logic                realign   = hit_found && cdet_s;
  // Boundary moves only on a fresh comma; otherwise it is held.
  wire rcad_pkg::rcad_pos_t bound_nxt = realign ? hit[3:0] : bound_r;
  // Realignment is a data multiplexer only; no clock is touched.
  wire rcad_pkg::rcad_sym_t aligned_nxt = window[bound_nxt +: 10];

  // Shift in raw words and latch the realigned character.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_r     <= 10'h000;
      old_r     <= 10'h000;
      aligned_r <= 10'h000;
      bound_r   <= `RCAD_BOUND_RST;
      sync1_r   <= 1'b0;
    end else begin
      raw_r     <= rx_raw_word;
      old_r     <= raw_r;
      aligned_r <= aligned_nxt;
      bound_r   <= bound_nxt;
      sync1_r   <= realign;
    end
  end

  // ========================================================================
  // Decode stage.
  logic rd_r;

  wire logic [5:0] s6 = {aligned_r[0], aligned_r[1], aligned_r[2],
                         aligned_r[3], aligned_r[4], aligned_r[5]};
  wire logic [3:0] s4 = {aligned_r[6], aligned_r[7], aligned_r[8], aligned_r[9]};
  wire logic       k28 = (s6 == `RCAD_K28_RDM) || (s6 == `RCAD_K28_RDP);
  // K28 in positive form carries an inverted trailing sub-block.
  wire logic [3:0] s4x = (s6 == `RCAD_K28_RDP) ? ~s4 : s4;
  wire logic [5:0] d6  = dec6(s6);
  wire logic [3:0] d4  = dec4(s4x);
  wire logic [4:0] x   = d6[4:0];
  wire logic       a7  = (s4 == `RCAD_A7_RDM) || (s4 == `RCAD_A7_RDP);
  wire logic       kx7 = a7 && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E);
  wire logic       a7_ok = k28 || kx7 || x == 5'h0B || x == 5'h0D || x == 5'h0E ||
                           x == 5'h11 || x == 5'h12 || x == 5'h14;
  wire logic       is_k = k28 || kx7;

  // Running disparity checks for both sub-blocks.
  wire logic [2:0] c6 = ones(s6);
  wire logic [2:0] c4 = ones({2'h0, s4});
  wire logic       e6 = (c6 == 3'h4 && rd_r) || (c6 == 3'h2 && !rd_r) ||
                        (s6 == `RCAD_D7_RDM && rd_r) || (s6 == `RCAD_D7_RDP && !rd_r);
  wire logic       rd_mid = (c6 == 3'h4) ? 1'b1 : ((c6 == 3'h2) ? 1'b0 : rd_r);
  wire logic       e4 = (c4 == 3'h3 && rd_mid) || (c4 == 3'h1 && !rd_mid) ||
                        (s4 == `RCAD_F3_RDM && rd_mid) || (s4 == `RCAD_F3_RDP && !rd_mid);
  wire logic       rd_nxt = (c4 == 3'h3) ? 1'b1 : ((c4 == 3'h1) ? 1'b0 : rd_mid);
  wire logic       code_err = !d6[5] || !d4[3] || (a7 && !a7_ok) || e6 || e4;

  // Select decoded byte, substitute byte, or raw character.
  wire rcad_pkg::rcad_sym_t bus_nxt =
    !codec_s ? aligned_r :
    code_err ? {2'h0, `RCAD_ERR_BYTE} :
               {2'h0, d4[2:0], d6[4:0]};
  wire logic k_nxt   = codec_s && is_k && !code_err;
  wire logic err_nxt = codec_s && code_err;

  // Output registers and running disparity.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r            <= `RCAD_RD_RST;
      rx_parallel_bus <= 10'h000;
      rx_k_flag       <= 1'b0;
      rx_code_error   <= 1'b0;
      comma_sync      <= 1'b0;
      boundary_pos    <= `RCAD_BOUND_RST;
    end else begin
      rd_r            <= codec_s ? rd_nxt : rd_r;
      rx_parallel_bus <= bus_nxt;
      rx_k_flag       <= k_nxt;
      rx_code_error   <= err_nxt;
      comma_sync      <= sync1_r;
      boundary_pos    <= bound_r;
    end
  end

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_COMMA_SYNC: assert property (realign |-> ##2 comma_sync)
    else $error("Comma found but sync not raised two cycles later.");
  AST_COMMA_WORD: assert property (sync1_r |-> aligned_r[6:0] == `RCAD_COMMA_POS)
    else $error("Sync raised on a character without the positive comma.");
  AST_NEG_IGNORE: assert property (!hit_found |=> !sync1_r)
    else $error("Sync raised without a positive comma.");
  AST_HOLD_BOUND: assert property (!realign |=> $stable(bound_r))
    else $error("Boundary moved without a comma.");
  AST_CDET_OFF: assert property (!cdet_s |=> ($stable(bound_r) && !sync1_r))
    else $error("Alignment acted while comma detection was off.");
  AST_ERR_BYTE: assert property (rx_code_error |->
                                 rx_parallel_bus[7:0] == `RCAD_ERR_BYTE)
    else $error("Code error without the all-ones byte.");
  // A clean K28 group must always come out flagged as control.
  AST_K_FLAG: assert property ((codec_s && !code_err &&
                               (s6 == `RCAD_K28_RDM || s6 == `RCAD_K28_RDP)) |=> rx_k_flag)
    else $error("Control character without K flag.");
  // Neither a K28 group nor an alternate trailing group means data only.
  AST_DATA_NO_K: assert property ((codec_s &&
                                   s6 != `RCAD_K28_RDM && s6 != `RCAD_K28_RDP &&
                                   s4 != `RCAD_A7_RDM && s4 != `RCAD_A7_RDP) |=> !rx_k_flag)
    else $error("K flag raised on a data character.");
  AST_CODEC_OFF: assert property (!codec_s |=> (!rx_k_flag && !rx_code_error &&
                                  rx_parallel_bus == $past(aligned_r)))
    else $error("Decoding active while codec disabled.");
  AST_K285: assert property ((codec_s && !rd_r && aligned_r == `RCAD_K285_SYM) |=>
                             (rx_k_flag && rx_parallel_bus[7:0] == `RCAD_K285_BYTE))
    else $error("K28.5 not decoded as a control byte.");

endmodule

//--- verif/rcad_link_src.sv
`timescale 1ns/10ps

// ==========================================================================
// Far-end serial source: emits the deserialized stream, first bit in bit 0.
module rcad_link_src (
  input  wire logic           ref_clk,
  output rcad_pkg::rcad_sym_t rx_raw_word
);
  logic                bits_q[$];
  int                  cur_off = 0;
  rcad_pkg::rcad_sym_t word_v;

  // Queues one character, first transmitted bit first.
  task automatic push_char(input rcad_pkg::rcad_sym_t c);
    for (int i = 0; i < 10; i++) begin
      bits_q.push_back(c[i]);
    end
  endtask

  // Slips the stream with alternating bits so no stray comma can form.
  task automatic realign(input int p);
    int n;
    n = (p - cur_off + 10) % 10;
    for (int i = 0; i < n; i++) begin
      bits_q.push_back(i[0]);
    end
    cur_off = p;
  endtask

  // Idle fill with a neutral data character keeps the stream continuous.
  always @(posedge ref_clk) begin
    while (bits_q.size() < 10) push_char(10'h155);
    for (int i = 0; i < 10; i++) begin
      word_v[i] = bits_q.pop_front();
    end
    rx_raw_word <= word_v;
  end
endmodule

//--- verif/tb_rx_comma_align_decode.sv
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_rx_comma_align_decode;
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                codec_enable = 1'b0;
  logic                comma_detect_enable = 1'b1;
  rcad_pkg::rcad_sym_t rx_raw_word;
  rcad_pkg::rcad_sym_t rx_parallel_bus;
  logic                rx_k_flag;
  logic                rx_code_error;
  logic                comma_sync;
  rcad_pkg::rcad_pos_t boundary_pos;
  int                  mismatches = 0;
  int                  samples_checked = 0;
  logic [12:0]         obs;

  // Observed outputs packed as {sync, k, error, bus}.
  assign obs = {comma_sync, rx_k_flag, rx_code_error, rx_parallel_bus};

  // ========================================================================
  // Clock, source model and design.
  always #10 ref_clk = ~ref_clk;

  rcad_link_src u_src (.ref_clk(ref_clk), .rx_raw_word(rx_raw_word));

  rcad_align u_dut (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .rx_raw_word        (rx_raw_word),
    .codec_enable       (codec_enable),
    .comma_detect_enable(comma_detect_enable),
    .rx_parallel_bus    (rx_parallel_bus),
    .rx_k_flag          (rx_k_flag),
    .rx_code_error      (rx_code_error),
    .comma_sync         (comma_sync),
    .boundary_pos       (boundary_pos)
  );

  // ========================================================================
  // Helpers.
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Waits a bounded time for the comma pulse.
  task automatic wait_sync();
    int n;
    n = 0;
    while (comma_sync !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
  endtask

  // Aligns at offset p with decode off, so running disparity stays frozen.
  task automatic prep(input logic [3:0] p);
    @(posedge ref_clk);
    codec_enable <= 1'b0;
    step(3);
    u_src.realign(p);
    u_src.push_char(10'h17C);
    u_src.push_char(10'h283);
    wait_sync();
    `CHK("raw_char", 13'h117C, obs)
    `CHK("bound_new", p, boundary_pos)
    @(posedge ref_clk);
    codec_enable <= 1'b1;
    step(4);
  endtask

  // Sends characters after alignment and checks each decoded output cycle.
  task automatic run_seq(input logic [3:0] p, input logic [9:0] ch[$],
                         input logic [12:0] ex[$]);
    prep(p);
    foreach (ch[i]) u_src.push_char(ch[i]);
    wait_sync();
    foreach (ex[i]) begin
      `CHK("char_out", ex[i], obs)
      step(1);
    end
    `CHK("bound_kept", p, boundary_pos)
  endtask

  // ========================================================================
  // Scenarios.
  task automatic t_align();
    logic [3:0] offs[3];
    offs = '{4'h0, 4'h3, 4'h9};
    foreach (offs[i]) begin
      run_seq(offs[i], '{10'h17C, 10'h283, 10'h155, 10'h07C, 10'h27C, 10'h283, 10'h0BC},
              '{13'h18BC, 13'h08BC, 13'h00B5, 13'h18FC, 13'h183C, 13'h08BC, 13'h081C});
    end
    $display("test align done");
  endtask

  // Commas at a new offset must be ignored while detection is off.
  task automatic t_cdet_off();
    @(posedge ref_clk);
    comma_detect_enable <= 1'b0;
    codec_enable <= 1'b0;
    step(4);
    u_src.realign(5);
    u_src.push_char(10'h17C);
    u_src.push_char(10'h283);
    repeat (30) begin
      `CHK("no_sync", 1'b0, comma_sync)
      `CHK("bound_held", 4'h9, boundary_pos)
      step(1);
    end
    @(posedge ref_clk);
    comma_detect_enable <= 1'b1;
    step(4);
    $display("test comma detect off done");
  endtask

  // Disparity error then invalid code word.
  task automatic t_error();
    run_seq(4'h2, '{10'h17C, 10'h17C, 10'h283, 10'h000},
            '{13'h18BC, 13'h14FF, 13'h08BC, 13'h04FF});
    $display("test errors done");
  endtask

  // ========================================================================
  // Verdict and end of run.
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    step(3);
    t_align();
    t_cdet_off();
    t_error();
    test_done();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
endmodule
